// >>> hw/fifo_host.sv
`timescale 1ns/1ns
`include "fifo_host_defs.svh"
// Notes on behaviour
// - writer holds data stable around the write strobe rising edge
// - writes near the full flag rising are unreliable; never relied upon
// - reads near the empty flag rising are unreliable; never relied upon
// - a reset must be applied after power-up before any write
// - both strobes high before and after pointer clear rises
module fifo_host
	import fifo_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// user side
	input wire logic clear_req,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire word_t wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output word_t rd_data,
	output host_status_t status,
	// device pins
	output logic write_n,
	output logic read_n,
	output logic pointer_clear_n,
	output logic chain_in_n,
	output logic lead_select_or_replay_n,
	output word_t in_bus,
	input wire word_t out_bus,
	input wire logic fill_limit_flag_n,
	input wire logic drained_flag_n,
	input wire logic chain_out_or_midpoint_n
);
	// ====================================================
	// timing counts
	// ====================================================
	localparam logic [`TIMER_W-1:0] CYC_WPULSE = `TIMER_W'(`NS_TO_CYC(`T_WRITE_PULSE_NS));
	// strobe held until the word has crossed all sync stages, else stale data is pushed
	localparam logic [`TIMER_W-1:0] CYC_RPULSE =
		`TIMER_W'(`NS_TO_CYC(`T_ACCESS_NS) + `SYNC_LAT + `SAMPLE_SLACK);
	localparam logic [`TIMER_W-1:0] CYC_WAFTER = `TIMER_W'(`NS_TO_CYC(`T_FLAG_DELAY_NS
		+ `T_WRITE_REC_NS + `T_DATA_HOLD_NS) + `SYNC_LAT);
	localparam logic [`TIMER_W-1:0] CYC_RAFTER =
		`TIMER_W'(`NS_TO_CYC(`T_FLAG_DELAY_NS + `T_READ_REC_NS) + `SYNC_LAT);
	localparam logic [`TIMER_W-1:0] CYC_CLEAR =
		`TIMER_W'(`NS_TO_CYC(`T_CLEAR_PULSE_NS + `T_CLEAR_SETUP_NS));
	localparam logic [`TIMER_W-1:0] CYC_CRECOV = `TIMER_W'(`NS_TO_CYC(`T_CLEAR_RECOVERY_NS
		+ `T_CLEAR_CYCLE_NS) + `SYNC_LAT);

	// ====================================================
	// pin input synchronisers
	// ====================================================
	wire [`PIN_VEC_W-1:0] pin_raw =
		{chain_out_or_midpoint_n, drained_flag_n, fill_limit_flag_n, out_bus};
	logic [`PIN_VEC_W-1:0] sync_a;
	logic [`PIN_VEC_W-1:0] sync_b;
	logic [`PIN_VEC_W-1:0] sync_c;
	logic [`PIN_VEC_W-1:0] pin_seen;

	// three sync flops plus the held value per bit; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `PIN_VEC_W; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					sync_a[gi] <= 1'b1;
					sync_b[gi] <= 1'b1;
					sync_c[gi] <= 1'b1;
					pin_seen[gi] <= 1'b1;
				end
				else
				begin
					sync_a[gi] <= pin_raw[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
					if (sync_b[gi] == sync_c[gi])
						pin_seen[gi] <= sync_c[gi];
				end
			end
		end
	endgenerate

	pin_flags_t flags;
	word_t seen_data;
	assign flags.fill_n = pin_seen[`PIN_FILL_BIT];
	assign flags.drained_n = pin_seen[`PIN_DRAIN_BIT];
	assign flags.mid_n = pin_seen[`PIN_MID_BIT];
	assign seen_data = pin_seen[`PIN_DATA_LSB +: `WORD_W];

	// ====================================================
	// sequencer
	// ====================================================
	typedef enum logic [2:0] {
		ST_CLEAR,
		ST_CRECOV,
		ST_IDLE,
		ST_WRITE,
		ST_WAFTER,
		ST_READ,
		ST_RAFTER
	} state_t;

	state_t state;
	state_t next_state;
	logic [`TIMER_W-1:0] timer;
	logic [`TIMER_W-1:0] next_timer;
	logic buf_in_ready;
	logic push_word;

	wire timer_done = (timer == `TIMER_W'(1));
	// flags as pins report them, active low; midpoint deliberately unused for gating
	wire may_write = flags.fill_n;
	wire may_read = flags.drained_n && buf_in_ready;
	wire take_write = (state == ST_IDLE) && !clear_req && wr_valid && may_write;
	wire take_read = (state == ST_IDLE) && !clear_req && !take_write && may_read;

	// write has priority; reads only start with buffer room so no word is lost
	assign wr_ready = take_write;
	assign push_word = (state == ST_READ) && timer_done;

	// next state and timer
	always_comb
	begin
		next_state = state;
		next_timer = timer - `TIMER_W'(1);
		unique case (state)
			ST_CLEAR:
				if (timer_done)
				begin
					next_state = ST_CRECOV;
					next_timer = CYC_CRECOV;
				end
			ST_CRECOV:
				if (timer_done)
					next_state = ST_IDLE;
			ST_IDLE:
			begin
				next_timer = timer;
				if (clear_req)
				begin
					next_state = ST_CLEAR;
					next_timer = CYC_CLEAR;
				end
				else if (take_write)
				begin
					next_state = ST_WRITE;
					next_timer = CYC_WPULSE;
				end
				else if (take_read)
				begin
					next_state = ST_READ;
					next_timer = CYC_RPULSE;
				end
			end
			ST_WRITE:
				if (timer_done)
				begin
					next_state = ST_WAFTER;
					next_timer = CYC_WAFTER;
				end
			ST_WAFTER:
				if (timer_done)
					next_state = ST_IDLE;
			ST_READ:
				if (timer_done)
				begin
					next_state = ST_RAFTER;
					next_timer = CYC_RAFTER;
				end
			ST_RAFTER:
				if (timer_done)
					next_state = ST_IDLE;
		endcase
	end

	// power-up starts with a pointer clear before any write
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_CLEAR;
			timer <= CYC_CLEAR;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// ====================================================
	// pin drivers, strobes and data from flops, mode pins at fixed levels
	// ====================================================
	// strobes stay high across the whole clear and its recovery
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			write_n <= 1'b1;
			read_n <= 1'b1;
			pointer_clear_n <= 1'b0;
		end
		else
		begin
			write_n <= !(next_state == ST_WRITE);
			read_n <= !(next_state == ST_READ);
			pointer_clear_n <= !(next_state == ST_CLEAR);
		end
	end

	// data held from strobe fall through the recovery wait, past the hold time
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			in_bus <= '0;
		else if (take_write)
			in_bus <= wr_data;
	end

	// single-device mode, no retransmit; fixed levels
	assign chain_in_n = 1'b0;
	assign lead_select_or_replay_n = 1'b1;

	// status; half taken from the shared chain-out pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status <= '{busy: 1'b1, half: 1'b0, empty: 1'b1, full: 1'b0};
		else
		begin
			status.busy <= (next_state == ST_CLEAR) || (next_state == ST_CRECOV);
			status.half <= !flags.mid_n;
			status.empty <= !flags.drained_n;
			status.full <= !flags.fill_n;
		end
	end

	// ====================================================
	// read data buffer
	// ====================================================
	word_skid_buffer u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_word),
		.in_ready(buf_in_ready),
		.in_data(seen_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);
endmodule : fifo_host

// >>> hw/fifo_host_defs.svh
`ifndef FIFO_HOST_DEFS_SVH
`define FIFO_HOST_DEFS_SVH
// clock and word
`define CLK_PERIOD_NS 4
`define WORD_W 9
`define TIMER_W 8
`define SYNC_LAT 3
// agree stage plus one cycle for a pin edge that lands on a clock edge
`define SAMPLE_SLACK 2
// array geometry, kept for reference; the bench model hard-codes 512 and 256 instead
`define ARRAY_WORDS 512
`define HALF_WORDS 256
// pin timing in ns, slowest grade so any grade is safe
`define T_WRITE_PULSE_NS 120
`define T_WRITE_REC_NS 20
`define T_DATA_HOLD_NS 10
`define T_ACCESS_NS 120
`define T_READ_REC_NS 20
`define T_FLAG_DELAY_NS 110
`define T_CLEAR_PULSE_NS 120
`define T_CLEAR_SETUP_NS 100
`define T_CLEAR_RECOVERY_NS 20
`define T_CLEAR_CYCLE_NS 140
// least time rounded up to whole cycles
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// field positions in the synchronised pin vector
`define PIN_VEC_W 12
`define PIN_DATA_LSB 0
`define PIN_FILL_BIT 9
`define PIN_DRAIN_BIT 10
`define PIN_MID_BIT 11
`endif

// >>> hw/fifo_host_pkg.sv
`include "fifo_host_defs.svh"
package fifo_host_pkg;
	typedef logic [`WORD_W-1:0] word_t;
	// flag pins as seen after synchronisation, all active low
	typedef struct packed {
		logic mid_n;
		logic drained_n;
		logic fill_n;
	} pin_flags_t;
	// user-side status, active high
	typedef struct packed {
		logic busy;
		logic half;
		logic empty;
		logic full;
	} host_status_t;
endpackage : fifo_host_pkg

// >>> hw/word_skid_buffer.sv
`timescale 1ns/1ns
`include "fifo_host_defs.svh"
module word_skid_buffer
	import fifo_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire word_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output word_t out_data
);
	// ====================================================
	// two-entry storage
	// ====================================================
	word_t slot [2];
	logic [1:0] count;
	logic wr_ptr;
	logic rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// honest full and empty from the count
	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);

	// read data straight from the register slot
	assign out_data = slot[rd_ptr];

	// pointers and count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= 2'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// data slots, no reset needed
	always_ff @(posedge clk)
	begin
		if (push)
			slot[wr_ptr] <= in_data;
	end
endmodule : word_skid_buffer

// >>> tb/fifo_host_checker.sv
`timescale 1ns/1ns
// ====
// pin rules kept by the host
module fifo_host_checker
	import fifo_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic pointer_clear_n,
	input wire word_t in_bus,
	input wire logic fill_limit_flag_n,
	input wire logic drained_flag_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic seen_clr;
	// a write only counts once a clear pulse has ended
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			seen_clr <= 1'b0;
		else if ($rose(pointer_clear_n))
			seen_clr <= 1'b1;
	AST_HOLD: assert property (!write_n |=> $stable(in_bus)[*3])
		else $error("data moved near strobe");
	AST_FIRST: assert property ($fell(write_n) |-> seen_clr)
		else $error("write before clear");
	AST_SETUP: assert property ($rose(pointer_clear_n) |-> $past(write_n, 25) && $past(read_n, 25))
		else $error("strobe low in clear setup");
	AST_RECOV: assert property ($rose(pointer_clear_n) |-> (write_n && read_n)[*6])
		else $error("strobe low in recovery");
	AST_FULL: assert property (!fill_limit_flag_n [*6] |-> !$fell(write_n))
		else $error("write while full");
	AST_EMPTY: assert property (!drained_flag_n [*6] |-> !$fell(read_n))
		else $error("read while empty");
	cover property ($fell(write_n));
	cover property ($fell(read_n) ##[1:80] !drained_flag_n);
	cover property ($fell(fill_limit_flag_n));
endmodule : fifo_host_checker

bind fifo_host fifo_host_checker chk_i
(
	.clk(clk),
	.rst_n(rst_n),
	.write_n(write_n),
	.read_n(read_n),
	.pointer_clear_n(pointer_clear_n),
	.in_bus(in_bus),
	.fill_limit_flag_n(fill_limit_flag_n),
	.drained_flag_n(drained_flag_n)
);

// >>> tb/fifo_dev_model.sv
`timescale 1ns/1ns
// ====
// behavioural 512-word device, strobe driven
module fifo_dev_model
	import fifo_host_pkg::*;
#(
	parameter int T_FLAG = 110,
	parameter int T_ACC = 120
)
(
	input wire logic write_n,
	input wire logic read_n,
	input wire logic pointer_clear_n,
	input wire logic chain_in_n,
	input wire word_t in_bus,
	output word_t out_bus,
	output logic fill_limit_flag_n,
	output logic drained_flag_n,
	output logic chain_out_or_midpoint_n
);
	word_t mem [512];
	word_t q = '0;
	int wp = 0;
	int rp = 0;
	int cnt = 0;
	bit wok, rok, drv, mid, single;
	// clear is a level; mode latched as it ends
	always @(pointer_clear_n)
		if (!pointer_clear_n)
		begin
			wp = 0;
			rp = 0;
			cnt = 0;
			mid = 0;
		end
		else
			single = !chain_in_n;
	// armed on the fall, stored on the rise
	always @(negedge write_n)
	begin
		wok = pointer_clear_n && cnt < 512;
		mid = mid | (cnt >= 256);
	end
	always @(posedge write_n)
		if (wok)
		begin
			mem[wp] = in_bus;
			wp = (wp + 1) % 512;
			cnt++;
		end
	// data only appears after the access time
	always @(negedge read_n)
	begin
		rok = pointer_clear_n && cnt > 0;
		q = mem[rp];
		#(T_ACC) drv = rok;
	end
	always @(posedge read_n)
	begin
		drv = 0;
		if (rok)
		begin
			rp = (rp + 1) % 512;
			cnt--;
			if (cnt <= 256)
				mid = 0;
		end
		rok = 0;
	end
	// a released bus shows the inverse, never a kind copy
	assign out_bus = drv ? q : ~q;
	assign #(T_FLAG) fill_limit_flag_n = cnt != 512;
	assign #(T_FLAG) drained_flag_n = cnt != 0;
	assign chain_out_or_midpoint_n = !(single && mid);
endmodule : fifo_dev_model

// >>> tb/testbench.sv
`timescale 1ns/1ns
// ====
// host bench: fill, drain and clear against the model
module testbench
	import fifo_host_pkg::*;
;
	logic clk = 0;
	logic rst_n = 0;
	logic clear_req = 0;
	logic wr_valid = 0;
	logic rd_ready = 0;
	word_t wr_data = '0;
	logic wr_ready, rd_valid, write_n, read_n, pointer_clear_n, chain_in_n, replay_n;
	logic fill_n, drained_n, mid_n;
	word_t rd_data, in_bus, out_bus;
	host_status_t status;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	fifo_host DUT
	(
		.clk(clk),
		.rst_n(rst_n),
		.clear_req(clear_req),
		.wr_valid(wr_valid),
		.wr_ready(wr_ready),
		.wr_data(wr_data),
		.rd_valid(rd_valid),
		.rd_ready(rd_ready),
		.rd_data(rd_data),
		.status(status),
		.write_n(write_n),
		.read_n(read_n),
		.pointer_clear_n(pointer_clear_n),
		.chain_in_n(chain_in_n),
		.lead_select_or_replay_n(replay_n),
		.in_bus(in_bus),
		.out_bus(out_bus),
		.fill_limit_flag_n(fill_n),
		.drained_flag_n(drained_n),
		.chain_out_or_midpoint_n(mid_n)
	);
	fifo_dev_model dev
	(
		.write_n(write_n),
		.read_n(read_n),
		.pointer_clear_n(pointer_clear_n),
		.chain_in_n(chain_in_n),
		.in_bus(in_bus),
		.out_bus(out_bus),
		.fill_limit_flag_n(fill_n),
		.drained_flag_n(drained_n),
		.chain_out_or_midpoint_n(mid_n)
	);
	task automatic chk(input bit ok, input string what);
		total_checks++;
		if (!ok)
		begin
			n_fail++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic settle;
		do @(negedge clk); while (status.busy !== 1'b0);
	endtask : settle
	// ====
	// user-side handshakes, sampled before the taking edge
	task automatic put(input word_t w);
		@(posedge clk) #1 wr_data = w;
		wr_valid = 1;
		do @(negedge clk); while (wr_ready !== 1'b1);
		@(posedge clk) #1 wr_valid = 0;
	endtask : put
	task automatic get(input word_t w);
		@(posedge clk) #1 rd_ready = 1;
		do @(negedge clk); while (rd_valid !== 1'b1);
		chk(rd_data === w, "read word out of order");
		@(posedge clk) #1 rd_ready = 0;
	endtask : get
	// ====
	// scenarios
	task automatic t_start;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		settle();
		chk(status === 4'h2, "status after power-up clear");
		chk(chain_in_n === 1'b0, "chain-in not low");
		chk(replay_n === 1'b1, "replay pin not idle");
	endtask : t_start
	task automatic t_fill;
		for (int i = 0; i < 514; i++) put(word_t'(i));
		repeat (100) @(posedge clk);
		#1 chk(status === 4'h5, "status when full");
		wr_valid = 1;
		repeat (200) @(negedge clk) chk(wr_ready === 1'b0, "write taken while full");
		@(posedge clk) #1 wr_valid = 0;
	endtask : t_fill
	// 9-bit words wrap, so words 512 and 513 are written and read back as 0 and 1
	task automatic t_drain;
		for (int i = 0; i < 514; i++) get(word_t'(i));
		repeat (100) @(posedge clk);
		chk(status === 4'h2, "status after drain");
	endtask : t_drain
	task automatic t_clear;
		for (int i = 0; i < 4; i++) put(word_t'(i + 7));
		repeat (200) @(posedge clk);
		#1 clear_req = 1;
		do @(negedge clk); while (status.busy !== 1'b1);
		@(posedge clk) #1 clear_req = 0;
		settle();
		chk(status === 4'h2, "status after user clear");
		get(9'h007);
		get(9'h008);
		repeat (200) @(negedge clk);
		chk(rd_valid === 1'b0, "word survived clear");
	endtask : t_clear
	initial
	begin
		t_start();
		t_fill();
		t_drain();
		t_clear();
		summarize();
	end
	// ceiling well above the roughly 75k cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			n_fail++;
			summarize();
		end
	end
endmodule : testbench
